// ---- include/can_wake_pkg.sv ----
package can_wake_pkg;
  localparam int CLK_MHZ = 100;
  // Wake and timeout timings (us, ns or ms as in each name)
  localparam int T_HV_INT_US = 100;
  localparam int T_BUS_INT_US = 80;
  localparam int T_CS_INT_US = 60;
  localparam int T_OC_DGLT_US = 55;
  localparam int T_OC_INT_US = 60;
  localparam int T_SAMPLE_LEAD_US = 10;
  localparam int T_DOM_TIMEOUT_US = 200;
  localparam int T_PAT_MAX_US = 500;
  localparam int T_PAT_WIN_US = 1000;
  localparam int T_PAT_MIN_NS = 500;
  localparam int T_INT_PULSE_US = 1;
  localparam int CYC_MIN_MS = 5;
  localparam int CYC_MAX_MS = 400;
  // Derived cycle counts
  localparam int N_HV_INT = T_HV_INT_US * CLK_MHZ;
  localparam int N_BUS_INT = T_BUS_INT_US * CLK_MHZ;
  localparam int N_CS_INT = T_CS_INT_US * CLK_MHZ;
  localparam int N_OC_DGLT = T_OC_DGLT_US * CLK_MHZ;
  localparam int N_OC_INT = T_OC_INT_US * CLK_MHZ;
  localparam int N_SAMPLE_LEAD = T_SAMPLE_LEAD_US * CLK_MHZ;
  localparam int N_DOM_TIMEOUT = T_DOM_TIMEOUT_US * CLK_MHZ;
  localparam int N_PAT_MAX = T_PAT_MAX_US * CLK_MHZ;
  localparam int N_PAT_WIN = T_PAT_WIN_US * CLK_MHZ;
  localparam int N_PAT_MIN = (T_PAT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int N_INT_PULSE = T_INT_PULSE_US * CLK_MHZ;
  localparam int N_PER_MS = 1000 * CLK_MHZ;
  // Reset values
  localparam logic [1:0] SLEW_RST = 2'h0;
  // Chip modes
  typedef enum logic [5:0] {
    CHIP_UNPOWERED = 6'h01,
    CHIP_RESET = 6'h02,
    CHIP_NORM_REQ = 6'h04,
    CHIP_NORMAL = 6'h08,
    CHIP_STANDBY = 6'h10,
    CHIP_LOWPWR = 6'h20
  } chip_mode_t;
endpackage

// ---- rtl/can_transceiver_mode_wakeup.sv ----
`timescale 1ns/1ps
`default_nettype none
module can_transceiver_mode_wakeup #(
  parameter int CYC_PERIOD_MS = 5,
  parameter int N_HV = can_wake_pkg::N_HV_INT,
  parameter int N_BUS = can_wake_pkg::N_BUS_INT,
  parameter int N_CS = can_wake_pkg::N_CS_INT,
  parameter int N_OCD = can_wake_pkg::N_OC_DGLT,
  parameter int N_OCI = can_wake_pkg::N_OC_INT,
  parameter int N_DOM = can_wake_pkg::N_DOM_TIMEOUT,
  parameter int N_PMAX = can_wake_pkg::N_PAT_MAX,
  parameter int N_PWIN = can_wake_pkg::N_PAT_WIN
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Chip state
  input wire can_wake_pkg::chip_mode_t chip_mode,
  input wire logic ballast_present,
  input wire logic peripheral_supply_ok,
  // Command controls
  input wire logic cmd_sleep,
  input wire logic cmd_normal,
  input wire logic [1:0] cmd_slew,
  input wire logic cmd_slew_wr,
  input wire logic wake_enable,
  input wire logic cyclic_enable,
  input wire logic [8:0] cyclic_timing_register,
  input wire logic bus_wake_flag_clr,
  // Pins
  input wire logic tx_pin,
  input wire logic bus_dominant,
  input wire logic hv_wake_input,
  input wire logic cs_n_pin,
  input wire logic main_regulator_overcurrent,
  // Outputs
  output logic rx_pin,
  output logic tx_pullup_en,
  output logic drv_dominant,
  output logic drv_recessive_bias,
  output logic [1:0] slew_rate,
  output logic can_sleep,
  output logic wake_rx_on,
  output logic bus_wake_flag,
  output logic tx_timeout_flag,
  output logic battery_high_side_switch,
  output logic int_n
);
  import can_wake_pkg::*;

  localparam int CW = 26;
  localparam int PW = 32;

  if (CYC_PERIOD_MS < CYC_MIN_MS || CYC_PERIOD_MS > CYC_MAX_MS)
    $error("cyclic period out of range");
  if (N_PWIN >= (1 << (CW - 1)) || N_HV >= (1 << (CW - 1)) ||
      N_DOM >= (1 << (CW - 1)) || N_OCD < 1)
    $error("count out of range");

  // ==========================================================
  // Input synchronisers
  logic [4:0] s1_reg;
  logic [4:0] s2_reg;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s1_reg <= 5'h1f;
      s2_reg <= 5'h1f;
    end
    else
    begin
      s1_reg <= {tx_pin, bus_dominant, hv_wake_input, cs_n_pin,
        main_regulator_overcurrent};
      s2_reg <= s1_reg;
    end
  end
  wire tx_s = s2_reg[4];
  wire dom_s = s2_reg[3];
  wire hv_s = s2_reg[2];
  wire cs_s = s2_reg[1];
  wire oc_s = s2_reg[0];

  logic hv_d_reg;
  logic cs_d_reg;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      hv_d_reg <= 1'b1;
      cs_d_reg <= 1'b1;
    end
    else
    begin
      hv_d_reg <= hv_s;
      cs_d_reg <= cs_s;
    end
  end

  wire stop_mode = (chip_mode == CHIP_LOWPWR);
  wire pwr_on = (chip_mode == CHIP_NORMAL) ||
    ((chip_mode == CHIP_STANDBY) && !ballast_present);
  wire v2_on = pwr_on && peripheral_supply_ok;

  // ==========================================================
  // Transceiver mode and slew
  logic sleep_reg;
  logic wake_en_reg;
  logic [1:0] slew_reg;
  always_ff @(posedge mclk)
  begin
    if (!rst_n || chip_mode == CHIP_NORM_REQ)
    begin
      sleep_reg <= 1'b0;
      slew_reg <= SLEW_RST;
      wake_en_reg <= 1'b0;
    end
    else
    begin
      if (cmd_sleep && !sleep_reg)
      begin
        sleep_reg <= 1'b1;
        wake_en_reg <= wake_enable;
      end
      else if (cmd_normal)
        sleep_reg <= 1'b0;
      if (cmd_slew_wr && !sleep_reg)
        slew_reg <= cmd_slew;
    end
  end

  // ==========================================================
  // Permanent dominant timeout
  logic [CW-1:0] dom_cnt_reg;
  logic tx_off_reg;
  always_ff @(posedge mclk)
  begin
    if (!rst_n || tx_s)
    begin
      dom_cnt_reg <= '0;
      tx_off_reg <= 1'b0;
    end
    else if (dom_cnt_reg == CW'(N_DOM))
      tx_off_reg <= 1'b1;
    else
      dom_cnt_reg <= dom_cnt_reg + 1'b1;
  end

  // ==========================================================
  // Pin outputs
  wire active = v2_on && !sleep_reg;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rx_pin <= 1'b0;
      tx_pullup_en <= 1'b0;
      drv_dominant <= 1'b0;
      drv_recessive_bias <= 1'b0;
      slew_rate <= SLEW_RST;
      can_sleep <= 1'b0;
      wake_rx_on <= 1'b0;
      tx_timeout_flag <= 1'b0;
    end
    else
    begin
      tx_pullup_en <= v2_on;
      if (active)
        rx_pin <= !dom_s;
      else
        rx_pin <= v2_on;
      drv_dominant <= active && !tx_s && !tx_off_reg;
      drv_recessive_bias <= active;
      slew_rate <= slew_reg;
      can_sleep <= sleep_reg;
      wake_rx_on <= sleep_reg && wake_en_reg;
      tx_timeout_flag <= tx_off_reg;
    end
  end

  // ==========================================================
  // Bus wake pattern detector
  logic [CW-1:0] pulse_cnt_reg;
  logic [CW-1:0] gap_cnt_reg;
  logic [CW-1:0] win_cnt_reg;
  logic [1:0] npulse_reg;
  logic dom_d_reg;
  logic bus_wake_pulse;
  wire arm = wake_rx_on;
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !arm)
    begin
      pulse_cnt_reg <= '0;
      gap_cnt_reg <= '0;
      win_cnt_reg <= '0;
      npulse_reg <= 2'h0;
      dom_d_reg <= 1'b0;
      bus_wake_pulse <= 1'b0;
    end
    else
    begin
      dom_d_reg <= dom_s;
      bus_wake_pulse <= 1'b0;
      if (npulse_reg != 2'h0)
        win_cnt_reg <= win_cnt_reg + 1'b1;
      if (dom_s)
      begin
        gap_cnt_reg <= '0;
        if (pulse_cnt_reg != CW'(N_PMAX))
          pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
      end
      else if (npulse_reg != 2'h0 && gap_cnt_reg != CW'(N_PMAX))
        gap_cnt_reg <= gap_cnt_reg + 1'b1;
      if ((npulse_reg != 2'h0) && (win_cnt_reg >= CW'(N_PWIN) ||
          gap_cnt_reg >= CW'(N_PMAX)))
      begin
        npulse_reg <= 2'h0;
        win_cnt_reg <= '0;
      end
      else if (dom_d_reg && !dom_s)
      begin
        pulse_cnt_reg <= '0;
        if (pulse_cnt_reg >= CW'(N_PAT_MIN) &&
            pulse_cnt_reg < CW'(N_PMAX))
        begin
          if (npulse_reg == 2'h2)
          begin
            bus_wake_pulse <= 1'b1;
            npulse_reg <= 2'h0;
            win_cnt_reg <= '0;
          end
          else
            npulse_reg <= npulse_reg + 1'b1;
        end
        else
        begin
          npulse_reg <= 2'h0;
          win_cnt_reg <= '0;
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n || bus_wake_flag_clr && !bus_wake_pulse)
      bus_wake_flag <= 1'b0;
    else if (bus_wake_pulse)
      bus_wake_flag <= 1'b1;
  end

  // ==========================================================
  // Cyclic sense of wake input
  logic [PW-1:0] cyc_cnt_reg;
  logic cyc_hit;
  wire [PW-1:0] cyc_per = PW'(cyclic_timing_register) * PW'(N_PER_MS);
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !cyclic_enable || !stop_mode)
    begin
      cyc_cnt_reg <= '0;
      cyc_hit <= 1'b0;
      battery_high_side_switch <= 1'b0;
    end
    else
    begin
      cyc_hit <= 1'b0;
      battery_high_side_switch <= cyc_cnt_reg < PW'(2 * N_SAMPLE_LEAD);
      if (cyc_cnt_reg + 1'b1 >= cyc_per)
        cyc_cnt_reg <= '0;
      else
        cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
      if (cyc_cnt_reg == PW'(N_SAMPLE_LEAD) && hv_s)
        cyc_hit <= 1'b1;
    end
  end

  // ==========================================================
  // Stop mode wake delays and interrupt
  function automatic logic [CW-1:0] tick(input logic [CW-1:0] c);
    tick = (c == '0) ? '0 : c - 1'b1;
  endfunction

  logic [CW-1:0] hv_t_reg;
  logic [CW-1:0] bus_t_reg;
  logic [CW-1:0] cs_t_reg;
  logic [CW-1:0] oc_t_reg;
  logic [CW-1:0] ocd_reg;
  logic [7:0] int_cnt_reg;
  wire hv_edge = cyclic_enable ? cyc_hit : (hv_s && !hv_d_reg);
  wire fire = (hv_t_reg == CW'(1)) || (bus_t_reg == CW'(1)) ||
    (cs_t_reg == CW'(1)) || (oc_t_reg == CW'(1));
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !stop_mode)
    begin
      hv_t_reg <= '0;
      bus_t_reg <= '0;
      cs_t_reg <= '0;
      oc_t_reg <= '0;
      ocd_reg <= '0;
    end
    else
    begin
      hv_t_reg <= (hv_edge && hv_t_reg == '0) ? CW'(N_HV) :
        tick(hv_t_reg);
      bus_t_reg <= (bus_wake_pulse && bus_t_reg == '0) ? CW'(N_BUS) :
        tick(bus_t_reg);
      cs_t_reg <= (cs_s && !cs_d_reg && cs_t_reg == '0) ? CW'(N_CS) :
        tick(cs_t_reg);
      ocd_reg <= oc_s ? ((ocd_reg == CW'(N_OCD)) ? ocd_reg :
        ocd_reg + 1'b1) : '0;
      oc_t_reg <= (oc_s && ocd_reg == CW'(N_OCD - 1) && oc_t_reg == '0) ?
        CW'(N_OCI) : tick(oc_t_reg);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      int_cnt_reg <= 8'h00;
      int_n <= 1'b1;
    end
    else if (fire && int_cnt_reg == 8'h00)
    begin
      int_cnt_reg <= 8'(N_INT_PULSE);
      int_n <= 1'b0;
    end
    else if (int_cnt_reg != 8'h00)
    begin
      int_cnt_reg <= int_cnt_reg - 1'b1;
      int_n <= (int_cnt_reg == 8'h01);
    end
    else
      int_n <= 1'b1;
  end
endmodule
`default_nettype wire

// ---- test/can_node_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// Controller and bus
module can_node_model (
  // Controller side
  input wire logic tx_bit,
  input wire logic remote_dom,
  // Transceiver side
  input wire logic drv_dominant,
  output logic tx_pin,
  output logic bus_dominant
);
  assign tx_pin = tx_bit;
  assign bus_dominant = drv_dominant | remote_dom;
endmodule
`default_nettype wire

// ---- test/can_transceiver_mode_wakeup_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module can_transceiver_mode_wakeup_test;
  import can_wake_pkg::*;
  localparam int NHV = 200, NBUS = 160, NCS = 120;
  localparam int NOCD = 110, NOCI = 120, NDOM = 400;
  logic mclk = 1'h0, rst_n = 1'h0, ballast_present = 1'h0;
  chip_mode_t chip_mode = CHIP_NORM_REQ;
  logic peripheral_supply_ok = 1'h1, cmd_sleep = 1'h0, cmd_normal = 1'h0;
  logic cmd_slew_wr = 1'h0, wake_enable = 1'h0, cyclic_enable = 1'h0;
  logic [1:0] cmd_slew = 2'h0;
  logic [8:0] cyclic_timing_register = 9'h005;
  logic bus_wake_flag_clr = 1'h0, tx_bit = 1'h1, remote_dom = 1'h0;
  logic hv_wake_input = 1'h0, cs_n_pin = 1'h1, oc = 1'h0;
  logic tx_pin, bus_dominant, rx_pin, tx_pullup_en, drv_dominant, hss;
  logic drv_recessive_bias, can_sleep, wake_rx_on, bus_wake_flag;
  logic tx_timeout_flag, int_n;
  logic [1:0] slew_rate;
  int failures = 0, checks_done = 0, cycles = 0;
  can_node_model i_node (.tx_bit(tx_bit), .remote_dom(remote_dom),
    .drv_dominant(drv_dominant), .tx_pin(tx_pin),
    .bus_dominant(bus_dominant));
  can_transceiver_mode_wakeup #(.N_HV(NHV), .N_BUS(NBUS), .N_CS(NCS),
    .N_OCD(NOCD), .N_OCI(NOCI), .N_DOM(NDOM), .N_PMAX(1000),
    .N_PWIN(2000)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .chip_mode(chip_mode), .ballast_present(ballast_present),
    .peripheral_supply_ok(peripheral_supply_ok), .cmd_sleep(cmd_sleep),
    .cmd_normal(cmd_normal), .cmd_slew(cmd_slew),
    .cmd_slew_wr(cmd_slew_wr), .wake_enable(wake_enable),
    .cyclic_enable(cyclic_enable),
    .cyclic_timing_register(cyclic_timing_register),
    .bus_wake_flag_clr(bus_wake_flag_clr), .tx_pin(tx_pin),
    .bus_dominant(bus_dominant), .hv_wake_input(hv_wake_input),
    .cs_n_pin(cs_n_pin), .main_regulator_overcurrent(oc),
    .rx_pin(rx_pin), .tx_pullup_en(tx_pullup_en),
    .drv_dominant(drv_dominant), .drv_recessive_bias(drv_recessive_bias),
    .slew_rate(slew_rate), .can_sleep(can_sleep),
    .wake_rx_on(wake_rx_on), .bus_wake_flag(bus_wake_flag),
    .tx_timeout_flag(tx_timeout_flag),
    .battery_high_side_switch(hss), .int_n(int_n));
  task automatic end_sim;
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wt(input int n);
    cyc(n);
    #1;
  endtask
  task automatic cmd(input logic s, nrm, w, input logic [1:0] v);
    cyc(1);
    {cmd_sleep, cmd_normal, cmd_slew_wr, cmd_slew} <= {s, nrm, w, v};
    cyc(1);
    {cmd_sleep, cmd_normal, cmd_slew_wr} <= 3'h0;
    wt(2);
  endtask
  task automatic pattern(input int len);
    repeat (3)
    begin
      cyc(100);
      remote_dom <= 1'h1;
      cyc(len);
      remote_dom <= 1'h0;
    end
  endtask
  task automatic wake(input int lo, input int hi);
    int n = 0;
    int w = 0;
    while (int_n !== 1'h0 && n < 600)
    begin
      wt(1);
      n++;
    end
    while (int_n === 1'h0 && w < 200)
    begin
      wt(1);
      w++;
    end
    chk("delay", n >= lo && n <= hi, 1);
    chk("width", w, N_INT_PULSE);
  endtask
  task automatic quiet(input int n);
    int k = 0;
    repeat (n)
    begin
      wt(1);
      k += int_n === 1'h0;
    end
    chk("extra int", k, 0);
  endtask
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_sim;
    end
  end
  initial
  begin
    cyc(6);
    rst_n <= 1'h1;
    wt(3);
    chk("rx", rx_pin, 0);
    chk("pullup", tx_pullup_en, 0);
    chk("slew", slew_rate, SLEW_RST);
    cyc(1);
    chip_mode <= CHIP_NORMAL;
    wt(5);
    chk("pullup", tx_pullup_en, 1);
    chk("rx", rx_pin, 1);
    cyc(1);
    tx_bit <= 1'h0;
    wt(6);
    chk("drv", drv_dominant, 1);
    chk("rx", rx_pin, 0);
    cyc(1);
    peripheral_supply_ok <= 1'h0;
    wt(5);
    chk("rx", rx_pin, 0);
    cyc(1);
    peripheral_supply_ok <= 1'h1;
    wt(NDOM);
    chk("drv", drv_dominant, 0);
    chk("txto", tx_timeout_flag, 1);
    cyc(1);
    tx_bit <= 1'h1;
    cyc(6);
    tx_bit <= 1'h0;
    wt(6);
    chk("drv", drv_dominant, 1);
    cyc(1);
    tx_bit <= 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      cmd(0, 0, 1, i[1:0]);
      chk("slew", slew_rate, i);
    end
    cmd(1, 0, 0, 2'h0);
    chk("sleep", can_sleep, 1);
    chk("wrx", wake_rx_on, 0);
    chk("rx", rx_pin, 1);
    cmd(0, 0, 1, 2'h1);
    chk("slew", slew_rate, 3);
    pattern(60);
    wt(20);
    chk("flag", bus_wake_flag, 0);
    cmd(0, 1, 0, 2'h0);
    chk("sleep", can_sleep, 0);
    chk("bias", drv_recessive_bias, 1);
    cyc(1);
    wake_enable <= 1'h1;
    cmd(1, 0, 0, 2'h0);
    chk("wrx", wake_rx_on, 1);
    pattern(1100);
    wt(20);
    chk("flag", bus_wake_flag, 0);
    pattern(60);
    wt(20);
    chk("flag", bus_wake_flag, 1);
    cyc(1);
    bus_wake_flag_clr <= 1'h1;
    cyc(1);
    {bus_wake_flag_clr, cs_n_pin} <= 2'h0;
    chip_mode <= CHIP_LOWPWR;
    wt(5);
    chk("rx", rx_pin, 0);
    chk("flag", bus_wake_flag, 0);
    chk("hss", hss, 0);
    cyc(1);
    cs_n_pin <= 1'h1;
    wake(NCS, NCS + 10);
    cyc(1);
    hv_wake_input <= 1'h1;
    wake(NHV, NHV + 10);
    cyc(1);
    {hv_wake_input, oc} <= 2'h1;
    wake(NOCD + NOCI, NOCD + NOCI + 12);
    cyc(1);
    oc <= 1'h0;
    pattern(60);
    wake(NBUS, NBUS + 12);
    cyc(1);
    cs_n_pin <= 1'h0;
    cyc(2);
    {cs_n_pin, hv_wake_input} <= 2'h3;
    wake(NCS, NCS + 10);
    quiet(300);
    cyc(1);
    cyclic_enable <= 1'h1;
    wt(1000);
    chk("hss", hss, 1);
    wake(NHV, NHV + 10);
    wt(800);
    chk("hss", hss, 0);
    cyc(1);
    cyclic_enable <= 1'h0;
    cyc(1);
    chip_mode <= CHIP_NORM_REQ;
    wt(3);
    chk("slew", slew_rate, SLEW_RST);
    chk("sleep", can_sleep, 0);
    cyc(1);
    chip_mode <= CHIP_STANDBY;
    ballast_present <= 1'h1;
    wt(5);
    chk("rx", rx_pin, 0);
    chk("pullup", tx_pullup_en, 0);
    cyc(1);
    ballast_present <= 1'h0;
    wt(5);
    chk("rx", rx_pin, 1);
    chk("pullup", tx_pullup_en, 1);
    end_sim;
  end
endmodule
`default_nettype wire

// ---- test/can_wake_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module can_wake_monitor #(
  parameter int N_HV = 200,
  parameter int N_CS = 120,
  parameter int N_DOM = 400
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Inputs
  input wire can_wake_pkg::chip_mode_t chip_mode,
  input wire logic peripheral_supply_ok,
  input wire logic cmd_sleep,
  input wire logic wake_enable,
  input wire logic cyclic_enable,
  input wire logic tx_pin,
  input wire logic bus_dominant,
  input wire logic hv_wake_input,
  input wire logic cs_n_pin,
  // Outputs
  input wire logic rx_pin,
  input wire logic tx_pullup_en,
  input wire logic drv_dominant,
  input wire logic can_sleep,
  input wire logic wake_rx_on,
  input wire logic int_n
);
  import can_wake_pkg::*;
  logic norm_on;
  logic pins_off;
  int tx_low_cnt;
  int int_low_cnt;
  assign norm_on = chip_mode == CHIP_NORMAL && !can_sleep
    && peripheral_supply_ok;
  assign pins_off = chip_mode inside {CHIP_UNPOWERED, CHIP_RESET,
    CHIP_NORM_REQ, CHIP_LOWPWR};
  always_ff @(posedge mclk)
  begin
    tx_low_cnt <= tx_pin ? 0 : tx_low_cnt + 1;
  end
  always_ff @(posedge mclk)
  begin
    int_low_cnt <= int_n ? 0 : int_low_cnt + 1;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_cs_edge;
    chip_mode == CHIP_LOWPWR && $rose(cs_n_pin) && int_n;
  endsequence
  sequence s_hv_edge;
    chip_mode == CHIP_LOWPWR && !cyclic_enable && $rose(hv_wake_input)
      && $stable(cs_n_pin) && int_n;
  endsequence
  AST_CS_WAKE:
    assert property (s_cs_edge |-> ##N_CS int_n ##[1:12] !int_n)
    else $error("chip select wake delay wrong");
  AST_HV_WAKE:
    assert property (s_hv_edge |-> ##N_HV int_n ##[1:12] !int_n)
    else $error("wake input delay wrong");
  AST_INT_WIDTH:
    assert property ($rose(int_n) |-> int_low_cnt == N_INT_PULSE)
    else $error("interrupt pulse width wrong");
  AST_RX_BUS:
    assert property ((norm_on && $stable(bus_dominant)) [*5]
      |-> rx_pin == !bus_dominant)
    else $error("receive output not following bus");
  AST_PINS_OFF:
    assert property (pins_off [*4]
      |-> !rx_pin && !tx_pullup_en && !drv_dominant)
    else $error("pins not low in off mode");
  AST_DRV_DOM:
    assert property ((!tx_pin && norm_on) [*5] ##0 tx_low_cnt < N_DOM
      |-> drv_dominant)
    else $error("driver not dominant on low transmit");
  AST_DRV_OFF:
    assert property (tx_low_cnt > N_DOM + 8 |-> !drv_dominant)
    else $error("driver not cut off after timeout");
  AST_SLEEP_CMD:
    assert property (cmd_sleep && !can_sleep && chip_mode == CHIP_NORMAL
      |-> ##2 can_sleep && wake_rx_on == $past(wake_enable, 2))
    else $error("sleep entry wrong");
endmodule
bind can_transceiver_mode_wakeup can_wake_monitor #(
  .N_HV(N_HV), .N_CS(N_CS), .N_DOM(N_DOM)) i_mon (
  .mclk(mclk), .rst_n(rst_n), .chip_mode(chip_mode),
  .peripheral_supply_ok(peripheral_supply_ok), .cmd_sleep(cmd_sleep),
  .wake_enable(wake_enable), .cyclic_enable(cyclic_enable),
  .tx_pin(tx_pin), .bus_dominant(bus_dominant),
  .hv_wake_input(hv_wake_input), .cs_n_pin(cs_n_pin), .rx_pin(rx_pin),
  .tx_pullup_en(tx_pullup_en), .drv_dominant(drv_dominant),
  .can_sleep(can_sleep), .wake_rx_on(wake_rx_on), .int_n(int_n));
`default_nettype wire
